// ---- src/sdrs_pkg.sv ----
package sdrs_pkg;
  // clock and time bases
  localparam int CLK_NS = 50;
  localparam int US_NS = 1000;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  // refresh periods in microseconds
  localparam int REF_CAP_US = 200;
  localparam int REF_FAST_US = 100;
  localparam int REF_S36_US = 125;
  localparam int REF_S76_US = 150;
  localparam int REF_S108_US = 175;
  localparam logic [11:0] CYC_CAP = 12'(REF_CAP_US * US_NS / CLK_NS);
  localparam logic [11:0] CYC_FAST = 12'(REF_FAST_US * US_NS / CLK_NS);
  localparam logic [11:0] CYC_S36 = 12'(REF_S36_US * US_NS / CLK_NS);
  localparam logic [11:0] CYC_S76 = 12'(REF_S76_US * US_NS / CLK_NS);
  localparam logic [11:0] CYC_S108 = 12'(REF_S108_US * US_NS / CLK_NS);
  // mapping limits and speed-table thresholds
  localparam int AMP_W = 6;
  localparam logic [5:0] FAST_MAX_AMPS = 6'h10;
  localparam logic [8:0] FAST_MAX_BYTES = 9'h010;
  localparam logic [8:0] S36_MAX_BYTES = 9'h024;
  localparam logic [8:0] S76_MAX_BYTES = 9'h04C;
  localparam logic [8:0] CAP_MAX_BYTES = 9'h15E;
  localparam logic [8:0] SPD_MAX_BYTES = 9'h06C;
  localparam logic [7:0] CAP_MAX_ITEMS = CAP_MAX_BYTES[8:1];
  localparam logic [7:0] SPD_MAX_ITEMS = SPD_MAX_BYTES[8:1];
  localparam int ITEM_W = 16;
  localparam int ITEM_AW = 8;
  // indicator pattern times in milliseconds
  localparam logic [10:0] FLICKER_MS = 11'h032;
  localparam logic [10:0] BLINK_MS = 11'h0C8;
  localparam logic [10:0] SF_ON_MS = 11'h0C8;
  localparam logic [10:0] SF_OFF_MS = 11'h3E8;
  // amplifier count settle window
  localparam int SETTLE_MS = 100;
  localparam int SETTLE_CYCLES = SETTLE_MS * MS_CYCLES;
  // register word offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_MAPSIZE = 12'h004;
  localparam logic [11:0] REG_COUNT = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_MASK = 12'h010;
  localparam logic [11:0] REG_PERIOD = 12'h014;
  localparam logic [3:0] IMG_PAGE = 4'h1;
  // control bits
  localparam int CTRL_SPEED = 0;
  localparam int CTRL_DC = 1;
  localparam int CTRL_FILT = 2;
  localparam int CTRL_DUMMY = 3;
  localparam int CTRL_W = 4;
  // status bits
  localparam int ST_DONE = 0;
  localparam int ST_MISM = 1;
  localparam int ST_CFG = 2;
  localparam int ST_OVR = 3;
  localparam int ST_REG = 4;
  localparam int ST_W = 5;
  // reset values and bus answers
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [8:0] MAPSIZE_RST = 9'h000;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {SDRS_IDLE, SDRS_RUN} sdrs_state_t;
endpackage : sdrs_pkg

// ---- src/sdrs_mem.sv ----
`timescale 1ns/1ps
module sdrs_mem #(
  parameter int DW = 16,
  parameter int AW = 8
) (
  input wire logic aclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_ff
);
  logic [DW-1:0] mem_ff [2**AW];

  if (DW < 1 || AW < 1) begin : g_bad
    $error("sdrs_mem: widths must be positive");
  end

  // one write port for the refresh engine
  always_ff @(posedge aclk) begin
    if (we) begin
      mem_ff[waddr] <= wdata;
    end
  end

  // registered read port for the bus
  always_ff @(posedge aclk) begin
    rdata_ff <= mem_ff[raddr];
  end
endmodule : sdrs_mem

// ---- src/sdrs_blink.sv ----
`timescale 1ns/1ps
module sdrs_blink
  import sdrs_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic flicker_ff,
  output logic blink_ff,
  output logic sflash_ff
);
  localparam int PW = $clog2(MS_CYC + 1);
  logic [PW-1:0] ms_cnt_ff;
  logic ms_tick_ff;
  logic [10:0] fl_cnt_ff;
  logic [10:0] bl_cnt_ff;
  logic [10:0] sf_cnt_ff;
  logic [10:0] nxt_sf_cnt;

  if (MS_CYC < 2) begin : g_bad
    $error("sdrs_blink: MS_CYC must be at least 2");
  end

  // millisecond prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_ff <= '0;
      ms_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff <= (ms_cnt_ff == PW'(MS_CYC - 1));
      ms_cnt_ff <= (ms_cnt_ff == PW'(MS_CYC - 1)) ? '0 : ms_cnt_ff + 1'b1;
    end
  end

  // flicker and blink: equal on and off halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl_cnt_ff <= '0;
      bl_cnt_ff <= '0;
      flicker_ff <= 1'b0;
      blink_ff <= 1'b0;
    end else if (ms_tick_ff) begin
      fl_cnt_ff <= (fl_cnt_ff == FLICKER_MS - 11'h001) ? '0 : fl_cnt_ff + 1'b1;
      bl_cnt_ff <= (bl_cnt_ff == BLINK_MS - 11'h001) ? '0 : bl_cnt_ff + 1'b1;
      if (fl_cnt_ff == FLICKER_MS - 11'h001) begin
        flicker_ff <= ~flicker_ff;
      end
      if (bl_cnt_ff == BLINK_MS - 11'h001) begin
        blink_ff <= ~blink_ff;
      end
    end
  end

  // single flash: short on phase, long off phase
  assign nxt_sf_cnt = (sf_cnt_ff == SF_ON_MS + SF_OFF_MS - 11'h001) ? '0 :
                      sf_cnt_ff + 1'b1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sf_cnt_ff <= '0;
      sflash_ff <= 1'b0;
    end else if (ms_tick_ff) begin
      sf_cnt_ff <= nxt_sf_cnt;
      sflash_ff <= (nxt_sf_cnt < SF_ON_MS);
    end
  end

  property p_flicker_half;
    @(posedge aclk) disable iff (!aresetn)
    (ms_tick_ff && fl_cnt_ff == FLICKER_MS - 11'h001)
      |=> (flicker_ff != $past(flicker_ff));
  endproperty
  a_flicker_half: assert property (p_flicker_half)
    else $error("flicker did not toggle at half period");

  property p_sflash_phase;
    @(posedge aclk) disable iff (!aresetn)
    (ms_tick_ff && sf_cnt_ff == SF_ON_MS - 11'h001) |=> !sflash_ff;
  endproperty
  a_sflash_phase: assert property (p_sflash_phase)
    else $error("single flash on phase too long");
endmodule : sdrs_blink

// ---- src/sdrs_top.sv ----
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module sdrs_top
  import sdrs_pkg::*;
#(
  parameter int IO_W = 60,
  parameter int SLICE_ITEMS = 8,
  parameter int MS_CYC = MS_CYCLES,
  parameter int SETTLE_CYC = SETTLE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sync0,
  input wire logic [AMP_W-1:0] amp_count,
  input wire logic [IO_W-1:0] io_bits,
  input wire logic hw_fail,
  input wire logic switch_bad,
  input wire logic nvm_bad,
  input wire logic link_up,
  input wire logic pd_active,
  input wire logic safe_op,
  output logic item_req,
  output logic [ITEM_AW-1:0] item_idx,
  input wire logic [ITEM_W-1:0] item_data,
  input wire logic item_valid,
  output logic [IO_W-1:0] io_image,
  output logic power_indicator,
  output logic link_act_ind,
  output logic run_ind,
  output logic err_ind,
  output logic irq
);
  localparam int SW = $clog2(SETTLE_CYC + 1);

  if (SLICE_ITEMS < 1 || SLICE_ITEMS > 175 || IO_W < 1 || SETTLE_CYC < 2)
  begin : g_bad
    $error("sdrs_top: parameter out of range");
  end

  logic aw_have_ff, w_have_ff, bvalid_ff, awready_ff, wready_ff;
  logic [11:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic wr_fire, nxt_aw_have, nxt_w_have, nxt_bvalid, wr_hit;
  logic arready_ff, rd_pend_ff, rvalid_ff, nxt_rd_pend, nxt_rvalid;
  logic [11:0] rd_addr_ff;
  logic [31:0] rdata_ff, rd_word;
  logic rd_hit;
  logic [11:0] img_ar_off, img_rd_off;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [8:0] map_ff;
  logic [ST_W-1:0] st_ff, mask_ff, ev, nxt_st;
  logic irq_ff;
  logic sync_s1_ff, sync_s2_ff, sync_s3_ff, sync_rise;
  logic [AMP_W-1:0] amp_s1_ff, amp_s2_ff, amp_s3_ff, reg_cnt_ff;
  logic [IO_W-1:0] io_s1_ff, io_s2_ff, io_image_ff;
  logic [2:0] err_s1_ff, err_s2_ff;
  logic [SW-1:0] settle_ff;
  logic reg_done_ff, mism_ff, cfg_bad_ff, amp_stable;
  logic speed, dc_en, cfg_bad;
  logic [8:0] lim_bytes;
  logic [9:0] map_p1;
  logic [7:0] items_eff, slice_len;
  logic [11:0] cur_period, per_cnt_ff;
  logic start;
  sdrs_state_t state_ff;
  logic [7:0] idx_ff, left_ff, ptr_ff, nxt_idx;
  logic item_req_ff;
  logic [ITEM_W-1:0] mem_rdata;
  logic flicker, blink, sflash;
  logic pwr_ff, link_ff, run_ff, err_ff, blink_err;

  assign speed = ctrl_ff[CTRL_SPEED];
  assign dc_en = ctrl_ff[CTRL_DC];

  // write channel handshake: address and data in either order
  assign wr_fire = aw_have_ff && w_have_ff;
  assign nxt_aw_have = aw_have_ff ? !wr_fire : (awvalid && awready_ff);
  assign nxt_w_have = w_have_ff ? !wr_fire : (wvalid && wready_ff);
  assign nxt_bvalid = bvalid_ff ? !bready : wr_fire;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= !nxt_aw_have && !nxt_bvalid;
      wready_ff <= !nxt_w_have && !nxt_bvalid;
      if (awvalid && awready_ff) aw_addr_ff <= awaddr;
      if (wvalid && wready_ff) begin
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
      if (wr_fire) bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // write decode: only writable words answer okay
  always_comb begin
    if (aw_addr_ff == REG_CTRL) wr_hit = 1'b1;
    else if (aw_addr_ff == REG_MAPSIZE) wr_hit = 1'b1;
    else if (aw_addr_ff == REG_COUNT) wr_hit = 1'b1;
    else if (aw_addr_ff == REG_MASK) wr_hit = 1'b1;
    else wr_hit = 1'b0;
  end

  // configuration registers set by the master
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
      map_ff <= MAPSIZE_RST;
      mask_ff <= MASK_RST;
    end else if (wr_fire && w_strb_ff[0]) begin
      if (aw_addr_ff == REG_CTRL) ctrl_ff <= w_data_ff[CTRL_W-1:0];
      else if (aw_addr_ff == REG_MAPSIZE) begin
        map_ff[7:0] <= w_data_ff[7:0];
        if (w_strb_ff[1]) map_ff[8] <= w_data_ff[8];
      end else if (aw_addr_ff == REG_MASK) mask_ff <= w_data_ff[ST_W-1:0];
    end
  end

  // read channel: answer one edge after the address is taken
  assign nxt_rd_pend = !rd_pend_ff && arvalid && arready_ff;
  assign nxt_rvalid = rvalid_ff ? !rready : rd_pend_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rd_addr_ff <= '0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      rd_pend_ff <= nxt_rd_pend;
      rvalid_ff <= nxt_rvalid;
      arready_ff <= !nxt_rd_pend && !nxt_rvalid;
      if (nxt_rd_pend) rd_addr_ff <= araddr;
      if (rd_pend_ff) begin
        rdata_ff <= rd_hit ? rd_word : '0;
        rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // item image window: word i sits at the page base plus four times i
  assign img_ar_off = araddr - {IMG_PAGE, 8'h00};
  assign img_rd_off = rd_addr_ff - {IMG_PAGE, 8'h00};

  // read decode of registers and the item image
  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    if (rd_addr_ff == REG_CTRL) rd_word[CTRL_W-1:0] = ctrl_ff;
    else if (rd_addr_ff == REG_MAPSIZE) rd_word[8:0] = map_ff;
    else if (rd_addr_ff == REG_COUNT) begin
      rd_word[5:0] = reg_cnt_ff;
      rd_word[13:8] = amp_s3_ff;
      rd_word[16] = reg_done_ff;
    end else if (rd_addr_ff == REG_STATUS) rd_word[ST_W-1:0] = st_ff;
    else if (rd_addr_ff == REG_MASK) rd_word[ST_W-1:0] = mask_ff;
    else if (rd_addr_ff == REG_PERIOD) begin
      rd_word[11:0] = cur_period;
      rd_word[16] = (state_ff == SDRS_RUN);
      rd_word[17] = cfg_bad_ff;
    end else if (rd_addr_ff[11:8] >= IMG_PAGE && img_rd_off[11:10] == 2'h0 &&
                 rd_addr_ff[1:0] == 2'h0)
      rd_word[ITEM_W-1:0] = mem_rdata;
    else rd_hit = 1'b0;
  end

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {sync_s1_ff, sync_s2_ff, sync_s3_ff} <= 3'h0;
      {amp_s1_ff, amp_s2_ff, amp_s3_ff} <= '0;
      {io_s1_ff, io_s2_ff} <= '0;
      {err_s1_ff, err_s2_ff} <= 6'h00;
    end else begin
      {sync_s3_ff, sync_s2_ff, sync_s1_ff} <= {sync_s2_ff, sync_s1_ff, sync0};
      {amp_s3_ff, amp_s2_ff, amp_s1_ff} <= {amp_s2_ff, amp_s1_ff, amp_count};
      {io_s2_ff, io_s1_ff} <= {io_s1_ff, io_bits};
      err_s1_ff <= {nvm_bad, switch_bad, hw_fail};
      err_s2_ff <= err_s1_ff;
    end
  end
  assign sync_rise = sync_s2_ff && !sync_s3_ff;
  assign amp_stable = (amp_s2_ff == amp_s3_ff);

  // amplifier count registration, override and mismatch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_ff <= '0;
      reg_done_ff <= 1'b0;
      reg_cnt_ff <= '0;
      mism_ff <= 1'b0;
    end else begin
      mism_ff <= reg_done_ff && amp_stable && (amp_s3_ff != reg_cnt_ff);
      if (wr_fire && w_strb_ff[0] && aw_addr_ff == REG_COUNT) begin
        reg_cnt_ff <= w_data_ff[AMP_W-1:0];
        reg_done_ff <= 1'b1;
      end else if (!reg_done_ff) begin
        // wait until the chain count holds still, whoever powered up last
        if (!amp_stable) settle_ff <= '0;
        else if (settle_ff == SW'(SETTLE_CYC - 1)) begin
          reg_cnt_ff <= amp_s3_ff;
          reg_done_ff <= 1'b1;
        end else settle_ff <= settle_ff + 1'b1;
      end
    end
  end

  // mapping limits per mode and effective item count
  assign lim_bytes = speed ? SPD_MAX_BYTES : CAP_MAX_BYTES;
  assign cfg_bad = (map_ff > lim_bytes);
  assign map_p1 = {1'b0, map_ff} + 10'h001;
  assign items_eff = cfg_bad ? lim_bytes[8:1] : map_p1[8:1];
  assign slice_len = (items_eff > 8'(SLICE_ITEMS)) ? 8'(SLICE_ITEMS) : items_eff;

  // free-run period selection
  always_comb begin
    if (!speed) cur_period = CYC_CAP;
    else if (reg_cnt_ff <= FAST_MAX_AMPS && map_ff <= FAST_MAX_BYTES &&
             !ctrl_ff[CTRL_FILT] && !ctrl_ff[CTRL_DUMMY])
      cur_period = CYC_FAST;
    else if (map_ff <= S36_MAX_BYTES) cur_period = CYC_S36;
    else if (map_ff <= S76_MAX_BYTES) cur_period = CYC_S76;
    else cur_period = CYC_S108;
  end

  // refresh tick: own period counter or the sync pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || dc_en) per_cnt_ff <= '0;
    else if (per_cnt_ff >= cur_period - 12'h001) per_cnt_ff <= '0;
    else per_cnt_ff <= per_cnt_ff + 1'b1;
  end
  assign start = dc_en ? sync_rise :
                 (per_cnt_ff >= cur_period - 12'h001);

  // discrete outputs follow every refresh cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) io_image_ff <= '0;
    else if (start) io_image_ff <= io_s2_ff;
  end

  // item refresh engine
  assign nxt_idx = (idx_ff + 8'h01 >= items_eff) ? 8'h00 : idx_ff + 8'h01;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= SDRS_IDLE;
      idx_ff <= '0;
      left_ff <= '0;
      ptr_ff <= '0;
      item_req_ff <= 1'b0;
    end else begin
      case (state_ff)
        SDRS_IDLE: begin
          if (start && items_eff != 8'h00) begin
            state_ff <= SDRS_RUN;
            item_req_ff <= 1'b1;
            if (speed) begin
              idx_ff <= '0;
              left_ff <= items_eff;
            end else begin
              idx_ff <= (ptr_ff >= items_eff) ? 8'h00 : ptr_ff;
              left_ff <= slice_len;
            end
          end
        end
        SDRS_RUN: begin
          if (item_valid) begin
            idx_ff <= nxt_idx;
            left_ff <= left_ff - 8'h01;
            if (left_ff == 8'h01) begin
              state_ff <= SDRS_IDLE;
              item_req_ff <= 1'b0;
              if (!speed) ptr_ff <= nxt_idx;
            end
          end
        end
        default: state_ff <= SDRS_IDLE;
      endcase
    end
  end

  sdrs_mem #(.DW(ITEM_W), .AW(ITEM_AW)) u_mem (
    .aclk(aclk),
    .we(state_ff == SDRS_RUN && item_valid),
    .waddr(idx_ff),
    .wdata(item_data),
    .raddr(img_ar_off[9:2]),
    .rdata_ff(mem_rdata)
  );

  // sticky status, cleared by reading it; a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_bad_ff <= 1'b0;
      st_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      cfg_bad_ff <= cfg_bad;
      st_ff <= nxt_st;
      irq_ff <= |(nxt_st & mask_ff); // drops with the status it reflects
    end
  end
  always_comb begin
    ev = '0;
    ev[ST_DONE] = (state_ff == SDRS_RUN) && item_valid && (left_ff == 8'h01);
    ev[ST_MISM] = reg_done_ff && amp_stable && (amp_s3_ff != reg_cnt_ff) &&
                  !mism_ff;
    ev[ST_CFG] = cfg_bad && !cfg_bad_ff;
    ev[ST_OVR] = start && (state_ff == SDRS_RUN);
    ev[ST_REG] = !reg_done_ff && amp_stable && settle_ff == SW'(SETTLE_CYC - 1);
  end
  // a status read clears the word, an event in that cycle survives
  assign nxt_st = (rd_pend_ff && rd_addr_ff == REG_STATUS) ? ev :
                  (st_ff | ev);

  sdrs_blink #(.MS_CYC(MS_CYC)) u_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .flicker_ff(flicker),
    .blink_ff(blink),
    .sflash_ff(sflash)
  );

  // status indicators
  assign blink_err = err_s2_ff[1] || err_s2_ff[2] || cfg_bad_ff || mism_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pwr_ff, link_ff, run_ff, err_ff} <= 4'h0;
    end else begin
      pwr_ff <= 1'b1;
      link_ff <= link_up && (pd_active ? flicker : 1'b1);
      if (err_s2_ff[0]) begin
        run_ff <= 1'b0;
        err_ff <= 1'b1;
      end else begin
        run_ff <= pd_active ? 1'b1 : (safe_op && sflash);
        err_ff <= blink_err && blink;
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign item_req = item_req_ff;
  assign item_idx = idx_ff;
  assign io_image = io_image_ff;
  assign power_indicator = pwr_ff;
  assign link_act_ind = link_ff;
  assign run_ind = run_ff;
  assign err_ind = err_ff;
  assign irq = irq_ff;

  property p_io_each;
    @(posedge aclk) disable iff (!aresetn)
    start |=> (io_image_ff == $past(io_s2_ff));
  endproperty
  a_io_each: assert property (p_io_each)
    else $error("discrete image not captured on refresh");

  property p_cap_period;
    @(posedge aclk) disable iff (!aresetn)
    !speed |-> (cur_period == CYC_CAP);
  endproperty
  a_cap_period: assert property (p_cap_period)
    else $error("capacity mode period wrong");

  property p_big_period;
    @(posedge aclk) disable iff (!aresetn)
    (speed && map_ff > S76_MAX_BYTES) |-> (cur_period == CYC_S108);
  endproperty
  a_big_period: assert property (p_big_period)
    else $error("speed mode large map period wrong");

  property p_dc_start;
    @(posedge aclk) disable iff (!aresetn)
    dc_en |-> (start == sync_rise);
  endproperty
  a_dc_start: assert property (p_dc_start)
    else $error("sync mode refresh not tied to pulse");

  property p_speed_all;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == SDRS_IDLE && start && speed && items_eff != 8'h00)
      |=> (left_ff == $past(items_eff) && idx_ff == 8'h00);
  endproperty
  a_speed_all: assert property (p_speed_all)
    else $error("speed mode does not refresh all items");

  property p_cap_slice;
    @(posedge aclk) disable iff (!aresetn)
    (state_ff == SDRS_IDLE && start && !speed && items_eff != 8'h00)
      |=> (left_ff == $past(slice_len));
  endproperty
  a_cap_slice: assert property (p_cap_slice)
    else $error("capacity slice length wrong");

  property p_mism;
    @(posedge aclk) disable iff (!aresetn)
    (reg_done_ff && amp_stable && amp_s3_ff != reg_cnt_ff) |=> mism_ff;
  endproperty
  a_mism: assert property (p_mism)
    else $error("count mismatch not flagged");

  property p_run_normal;
    @(posedge aclk) disable iff (!aresetn)
    (pd_active && !err_s2_ff[0]) |=> (run_ff && pwr_ff) ##1 pwr_ff;
  endproperty
  a_run_normal: assert property (p_run_normal)
    else $error("run indicator not on in normal exchange");

  property p_hw_fail;
    @(posedge aclk) disable iff (!aresetn)
    err_s2_ff[0] |=> (!run_ff && err_ff);
  endproperty
  a_hw_fail: assert property (p_hw_fail)
    else $error("hardware failure indication wrong");

  property p_err_blink;
    @(posedge aclk) disable iff (!aresetn)
    (!err_s2_ff[0] && cfg_bad_ff) |=> (err_ff == $past(blink));
  endproperty
  a_err_blink: assert property (p_err_blink)
    else $error("error indicator not blinking on bad config");
endmodule : sdrs_top

// ---- sim/sdrs_chain_model.sv ----
`timescale 1ns/1ps
module sdrs_chain_model
  import sdrs_pkg::*;
#(
  parameter int LAT = 3
) (
  input wire logic aclk,
  input wire logic item_req,
  input wire logic [ITEM_AW-1:0] item_idx,
  input wire logic [7:0] tag,
  output logic [ITEM_W-1:0] item_data = '0,
  output logic item_valid = '0
);
  int gap_ff = 0;
  logic go;
  // answer when a request has waited LAT cycles since the last pulse
  assign go = item_req && !item_valid && gap_ff >= LAT;
  // one pulse per item; idle data lines toggle every cycle
  always_ff @(posedge aclk) begin
    gap_ff <= item_valid ? 0 : gap_ff + 1;
    item_valid <= go;
    item_data <= go ? {tag, item_idx} : ~item_data;
  end
endmodule : sdrs_chain_model

// ---- sim/test_sdrs_top.sv ----
`timescale 1ns/1ps
module test_sdrs_top
  import sdrs_pkg::*;
;
  logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
  logic arvalid = '0, rready = '0, sync0 = '0, hw_fail = '0, nvm_bad = '0;
  logic switch_bad = '0, link_up = '0, pd_active = '0, safe_op = '0;
  logic awready, wready, bvalid, arready, rvalid, item_req, item_valid;
  logic power_indicator, link_act_ind, run_ind, err_ind, irq;
  logic [1:0] bresp, rresp, br;
  logic [3:0] wstrb = 4'hF;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [5:0] amp_count = 6'h05;
  logic [59:0] io_bits = 60'h0_89AB_CDEF, io_image;
  logic [7:0] item_idx, tag = '0;
  logic [15:0] item_data;
  logic [3:0] tc [9] = '{1, 5, 9, 1, 1, 1, 1, 1, 12};
  logic [8:0] ts [9] = '{16, 16, 16, 36, 37, 76, 77, 108, 350};
  logic [11:0] te [9] = '{CYC_FAST, CYC_S36, CYC_S36, CYC_S36, CYC_S76,
    CYC_S76, CYC_S108, CYC_S108, CYC_CAP};
  wire logic [2:0] ind = {run_ind, err_ind, link_act_ind};
  int bad_count = 0, compares = 0, n;

  sdrs_top #(.MS_CYC(20), .SETTLE_CYC(16)) dut (.*);
  sdrs_chain_model far_end (.*);

  // 20 MHz clock and hang guard
  initial forever #25 aclk = ~aclk;
  initial begin
    #(95000 * 50);
    bad_count++;
    wrap_up();
  end

  task wrap_up;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %0t %h %h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (pa || pw) begin
      @(posedge aclk);
      pa = pa && awready !== 1'h1;
      pw = pw && wready !== 1'h1;
      awvalid <= pa;
      wvalid <= pw;
    end
    bready <= 1'h1;
    do @(posedge aclk); while (bvalid !== 1'h1);
    br = bresp;
    bready <= 1'h0;
  endtask : wr

  task rr(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    rd = rdata;
  endtask : rr

  // item image words hold the tag of the latest refresh
  task scan(input int k);
    for (int i = 0; i < k; i++) begin
      rr(12'(256 + 4 * i));
      chk(rd, {16'h0, tag, 8'(i)});
    end
  endtask : scan

  // cycles that indicator b spends at level v, one whole phase
  task span(input int b, input logic v, output int c);
    c = 0;
    while (ind[b] === v) @(posedge aclk);
    while (ind[b] !== v) @(posedge aclk);
    while (ind[b] === v) begin
      c++;
      @(posedge aclk);
    end
  endtask : span

  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (30) @(posedge aclk);
    rr(REG_COUNT);
    chk(rd, 32'h0001_0505);
    rr(12'h0FC);
    chk(32'(rresp), 32'(RESP_SLVERR));
    wr(REG_STATUS, 32'h0);
    chk(32'(br), 32'(RESP_SLVERR));
    amp_count <= 6'h06;
    wr(REG_MASK, 32'h2);
    chk(32'(br), 32'(RESP_OKAY));
    repeat (10) @(posedge aclk);
    chk(32'(irq), 32'h1);
    wr(REG_COUNT, 32'h6);
    rr(REG_STATUS);
    chk(32'(rd[ST_MISM]), 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0);
    for (int i = 0; i < 9; i++) begin
      wr(REG_CTRL, 32'(tc[i]));
      wr(REG_MAPSIZE, 32'(ts[i]));
      rr(REG_PERIOD);
      chk(rd & 32'h0002_0FFF, 32'(te[i]));
    end
    wr(REG_MAPSIZE, 32'h15F);
    rr(REG_PERIOD);
    chk(32'(rd[17]), 32'h1);
    wr(REG_CTRL, 32'h1);
    wr(REG_MAPSIZE, 32'h10);
    tag <= 8'h5A;
    repeat (4100) @(posedge aclk);
    chk(io_image[31:0], 32'h89AB_CDEF);
    scan(8);
    wr(REG_CTRL, 32'h0);
    wr(REG_MAPSIZE, 32'h20);
    tag <= 8'h3C;
    repeat (12100) @(posedge aclk);
    scan(16);
    wr(REG_CTRL, 32'h2);
    io_bits <= 60'h5;
    repeat (5000) @(posedge aclk);
    chk(io_image[31:0], 32'h89AB_CDEF);
    sync0 <= 1'h1;
    repeat (10) @(posedge aclk);
    chk(io_image[31:0], 32'h5);
    sync0 <= 1'h0;
    link_up <= 1'h1;
    pd_active <= 1'h1;
    repeat (10) @(posedge aclk);
    chk(32'({power_indicator, ind[2:1]}), 32'h6);
    span(0, 1'h1, n);
    chk(32'(n), 32'h3E8);
    hw_fail <= 1'h1;
    repeat (10) @(posedge aclk);
    chk(32'(ind[2:1]), 32'h1);
    hw_fail <= 1'h0;
    switch_bad <= 1'h1;
    span(1, 1'h1, n);
    chk(32'(n), 32'hFA0);
    switch_bad <= 1'h0;
    pd_active <= 1'h0;
    safe_op <= 1'h1;
    // let run leave its steady on level so no partial off phase is counted
    repeat (3) @(posedge aclk);
    span(2, 1'h0, n);
    chk(32'(n), 32'h4E20);
    wrap_up();
  end
endmodule : test_sdrs_top
